// ### include/fbm_pkg.sv
// package: mode codes, address map constants and strap timing for fbm block
package fbm_pkg;
    // operating modes latched at reset release, one-hot codes
    typedef enum logic [4:0] {
        FBM_MODE_NONE   = 5'h01,
        FBM_MODE_SCHIP  = 5'h02,
        FBM_MODE_SBOOT  = 5'h04,
        FBM_MODE_PROG   = 5'h08,
        FBM_MODE_BAD    = 5'h10
    } fbm_mode_e;

    // decoded target of one physical access
    typedef enum logic [3:0] {
        FBM_SEL_NONE  = 4'h1,
        FBM_SEL_FLASH = 4'h2,
        FBM_SEL_BROM  = 4'h4,
        FBM_SEL_RAM   = 4'h8
    } fbm_sel_e;

    localparam int FBM_AW = 32;
    localparam logic [31:0] FBM_USER_BASE  = 32'h1fc0_0000;
    localparam logic [31:0] FBM_USER_LAST  = 32'h1fcf_ffff;
    localparam logic [31:0] FBM_IRQ_BASE   = 32'h1fc0_0400;
    localparam logic [31:0] FBM_BROM_LAST  = 32'h1fc0_1fff;
    localparam logic [31:0] FBM_SHAD_BASE  = 32'h4000_0000;
    localparam logic [31:0] FBM_SHAD_LAST  = 32'h400f_ffff;
    localparam logic [31:0] FBM_PROG_BASE  = 32'h0000_0000;
    localparam logic [31:0] FBM_PROG_LAST  = 32'h000f_ffff;
    localparam logic [31:0] FBM_RAM_BASE   = 32'hfffd_6000;
    localparam logic [31:0] FBM_RAM_LAST   = 32'hfffd_ffff;
    localparam logic [31:0] FBM_BLK_SIZE   = 32'h0002_0000;
    localparam logic [19:0] FBM_OFS_MASK   = 20'hf_ffff;
    localparam int FBM_BLK_CNT = 8;
    localparam int FBM_BLK_LSB = 17;
    // least reset length in system clocks
    localparam int FBM_RST_MIN_CLK = 12;
    localparam logic [3:0] FBM_RST_CNT_MAX = 4'hc;
endpackage

// ### include/fbm_dec_if.sv
// interface: address decode request and answer between fbm modules
`timescale 1ns/10ps
interface fbm_dec_if;
    logic [31:0] addr;
    logic [4:0] mode;
    logic [3:0] sel;
    logic [19:0] ofs;
    logic [2:0] blk;
    logic vector_hit;
    modport ctl (output addr, output mode,
                 input sel, input ofs, input blk, input vector_hit);
    modport dec (input addr, input mode,
                 output sel, output ofs, output blk, output vector_hit);
endinterface

// ### design/fbm_addr_dec.sv
// module: combinational physical address decoder for each latched mode
`timescale 1ns/10ps
module fbm_addr_dec (
    // decode link
    fbm_dec_if.dec dif
);
    import fbm_pkg::*;

    logic in_user;
    logic in_shad;
    logic in_prog;
    logic in_brom;
    logic in_ram;

    // window compares shared by all modes
    always_comb begin
        in_user = (dif.addr >= FBM_USER_BASE) && (dif.addr <= FBM_USER_LAST);
        in_shad = (dif.addr >= FBM_SHAD_BASE) && (dif.addr <= FBM_SHAD_LAST);
        in_prog = (dif.addr <= FBM_PROG_LAST);
        in_brom = (dif.addr >= FBM_USER_BASE) && (dif.addr <= FBM_BROM_LAST);
        in_ram = (dif.addr >= FBM_RAM_BASE) && (dif.addr <= FBM_RAM_LAST);
    end

    // per-mode target select; anything unmatched selects nothing
    always_comb begin
        dif.sel = FBM_SEL_NONE;
        dif.ofs = dif.addr[19:0] & FBM_OFS_MASK;
        dif.vector_hit = 1'b0;
        case (dif.mode)
            FBM_MODE_SCHIP: begin
                // user flash low, shadow high; boot submode aliases too
                if (in_user || in_shad) begin
                    dif.sel = FBM_SEL_FLASH;
                end else if (in_ram) begin
                    dif.sel = FBM_SEL_RAM;
                end
                dif.vector_hit = in_user && (dif.addr < FBM_IRQ_BASE);
            end
            FBM_MODE_SBOOT: begin
                if (in_brom) begin
                    dif.sel = FBM_SEL_BROM;
                end else if (in_shad) begin
                    dif.sel = FBM_SEL_FLASH;
                end else if (in_ram) begin
                    dif.sel = FBM_SEL_RAM;
                end
            end
            FBM_MODE_PROG: begin
                if (in_prog) begin
                    dif.sel = FBM_SEL_FLASH;
                end
            end
            default: begin
                dif.sel = FBM_SEL_NONE;
            end
        endcase
    end

    // 128 KB block number from the flash offset
    assign dif.blk = dif.ofs[FBM_BLK_LSB +: 3];
endmodule

// ### design/fbm_mode_ctl.sv
// module: strap-driven mode latch, fetch control and address select top
`timescale 1ns/10ps
// How it works
// - single-chip mode starts fetching from on-chip flash after reset release
// - single boot mode fetches from the 8 KB boot ROM instead
// - boot ROM routine reprograms flash from serial host data
// - mode decoded from width, loader and interleave straps across reset
// - loader and interleave strap pins become general I/O after release
// - cpu runs in single-chip and single boot modes only
// - single boot maps boot ROM low and flash at the high window
// - normal mode maps user flash low with a shadow copy high
// - programmer mode maps flash at zero, all else inaccessible
// - flash blocks are 128 KB windows, aliased high in user boot
// - interleave mode latched from port j bit3 at the first clock after reset release
// - flash writes only in user boot, single boot or programmer
// - cpu uses 32-bit flash path, programmer writes 16-bit only
module fbm_mode_ctl (
    // clock and reset; sys_rst_i mirrors the active-low pin inverted
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // strap pins
    input wire logic width_strap_lo_i,
    input wire logic width_strap_hi_i,
    input wire logic loader_strap_n_i,
    input wire logic port_j_bit3_i,
    // software submode request: user boot when set
    input wire logic user_boot_sel_i,
    // cpu access
    input wire logic [31:0] cpu_addr_i,
    input wire logic cpu_write_i,
    // mode status
    output fbm_pkg::fbm_mode_e mode_o,
    output logic mode_valid_o,
    output logic cpu_run_o,
    output logic fetch_brom_o,
    output logic interleave_o,
    output logic straps_free_o,
    output logic reset_short_o,
    output logic prog_16bit_o,
    // access select
    output logic sel_flash_o,
    output logic sel_brom_o,
    output logic sel_ram_o,
    output logic vector_hit_o,
    output logic [2:0] flash_blk_o,
    output logic [19:0] flash_ofs_o,
    output logic flash_wr_ok_o
);
    import fbm_pkg::*;

    fbm_mode_e mode;
    fbm_mode_e next_mode;
    logic interleave;
    logic next_interleave;
    logic released;
    logic next_released;
    bit [3:0] hold_cnt;
    logic [3:0] next_hold_cnt;
    logic short_rst;
    logic next_short_rst;
    fbm_mode_e strap_mode;

    fbm_dec_if dif ();

    // strap decode while reset is held; sys_rst_i high means pin low
    always_comb begin
        if (!width_strap_lo_i && width_strap_hi_i) begin
            strap_mode = FBM_MODE_PROG;
        end else if (width_strap_lo_i && width_strap_hi_i
                     && !loader_strap_n_i) begin
            strap_mode = FBM_MODE_SBOOT;
        end else if (width_strap_lo_i && width_strap_hi_i
                     && port_j_bit3_i) begin
            strap_mode = FBM_MODE_SCHIP;
        end else begin
            strap_mode = FBM_MODE_BAD; // unsupported combination
        end
    end

    // capture once at the first clock after release, then hold
    always_comb begin
        next_mode = mode;
        next_interleave = interleave;
        next_released = 1'b1;
        next_short_rst = short_rst;
        if (!released) begin
            next_mode = strap_mode;
            next_interleave = port_j_bit3_i;
        end
        if (!released && hold_cnt != FBM_RST_CNT_MAX) begin
            next_short_rst = 1'b1; // reset shorter than 12 clocks
        end
    end

    // latch state clears at once while reset is held
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode <= FBM_MODE_NONE;
            interleave <= 1'b0;
            released <= 1'b0;
            short_rst <= 1'b0;
        end else begin
            mode <= next_mode;
            interleave <= next_interleave;
            released <= next_released;
            short_rst <= next_short_rst;
        end
    end

    // count clocks seen with reset held, saturating at the minimum
    always_comb begin
        next_hold_cnt = 4'h0; // running: start afresh at the next reset
        if (sys_rst_i) begin
            next_hold_cnt = hold_cnt;
        end
        if (sys_rst_i && hold_cnt != FBM_RST_CNT_MAX) begin
            next_hold_cnt = hold_cnt + 4'h1;
        end
    end

    // no async clear: the count must run while reset is asserted; the
    // 2-state counter starts at zero, but a power-up value on silicon may
    // hide a short first reset, so only later resets are judged reliably
    always_ff @(posedge sys_clk_i) begin
        hold_cnt <= next_hold_cnt;
    end

    // programmer mode keeps reset low, so it is seen live on the straps
    fbm_mode_e eff_mode;
    always_comb begin
        if (sys_rst_i && !width_strap_lo_i && width_strap_hi_i) begin
            eff_mode = FBM_MODE_PROG;
        end else begin
            eff_mode = mode;
        end
    end

    assign dif.addr = cpu_addr_i;
    assign dif.mode = eff_mode;

    fbm_addr_dec u_dec (
        .dif(dif)
    );

    // status outputs
    assign mode_o = eff_mode;
    assign mode_valid_o = released;
    // cpu runs after release in single-chip or single boot mode only
    assign cpu_run_o = released && (mode == FBM_MODE_SCHIP
                                    || mode == FBM_MODE_SBOOT);
    // fetch source: boot ROM only in single boot, flash otherwise
    assign fetch_brom_o = (mode == FBM_MODE_SBOOT);
    assign interleave_o = interleave;
    // loader and interleave strap pins released to general I/O
    assign straps_free_o = released;
    assign reset_short_o = short_rst;
    // external programmer path is half word wide
    assign prog_16bit_o = (eff_mode == FBM_MODE_PROG);

    // access selects; programmer holds the cpu in reset
    assign sel_flash_o = dif.sel == FBM_SEL_FLASH;
    assign sel_brom_o = dif.sel == FBM_SEL_BROM;
    assign sel_ram_o = dif.sel == FBM_SEL_RAM;
    assign vector_hit_o = dif.vector_hit;
    assign flash_blk_o = dif.blk;
    assign flash_ofs_o = dif.ofs;
    // writes allowed in user boot, single boot or programmer only
    assign flash_wr_ok_o = cpu_write_i && sel_flash_o
        && ((eff_mode == FBM_MODE_SCHIP && user_boot_sel_i)
            || eff_mode == FBM_MODE_SBOOT || eff_mode == FBM_MODE_PROG);

    AST_MODE_HELD: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) $past(released) |-> $stable(mode))
        else $error("latched mode changed without reset");
    // programmer mode lives under reset, so these two are never disabled
    AST_NO_RUN_PROG: assert property (@(posedge sys_clk_i)
        eff_mode == FBM_MODE_PROG |-> !cpu_run_o)
        else $error("cpu running in programmer mode");
    AST_PROG_ONLY_LOW: assert property (@(posedge sys_clk_i)
        (eff_mode == FBM_MODE_PROG && cpu_addr_i > FBM_PROG_LAST)
        |-> !(sel_flash_o || sel_brom_o || sel_ram_o))
        else $error("programmer mode selected a region above flash");
    AST_NORMAL_NO_WR: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        (mode == FBM_MODE_SCHIP && !user_boot_sel_i) |-> !flash_wr_ok_o)
        else $error("flash write allowed in normal mode");
    AST_BOOT_FETCH: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        (mode == FBM_MODE_SBOOT && cpu_addr_i >= FBM_USER_BASE
         && cpu_addr_i <= FBM_BROM_LAST) |-> fetch_brom_o && sel_brom_o)
        else $error("single boot not fetching from boot rom");
    // release is two steps: reset falls, one clock later the mode is held
    sequence seq_rst_fall;
        $fell(sys_rst_i);
    endsequence
    sequence seq_mode_latched;
        released && (mode != FBM_MODE_NONE);
    endsequence
    AST_RELEASE_ONE: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) seq_rst_fall |=> seq_mode_latched)
        else $error("straps not released one clock after reset");
    AST_ILV_CAPTURE: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        $rose(released) |-> interleave == $past(port_j_bit3_i))
        else $error("interleave not captured at release");
    AST_SCHIP_RUN: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        (released && mode == FBM_MODE_SCHIP && cpu_addr_i >= FBM_USER_BASE
         && cpu_addr_i <= FBM_USER_LAST)
        |-> cpu_run_o && !fetch_brom_o && sel_flash_o)
        else $error("single chip not running from flash");
    AST_BAD_NO_SEL: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        mode == FBM_MODE_BAD |-> !(sel_flash_o || sel_brom_o || sel_ram_o))
        else $error("unsupported mode selected memory");
    // a short reset stays flagged until the next reset
    AST_SHORT_STICKY: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        (released && $past(short_rst)) |-> short_rst)
        else $error("short reset flag cleared without reset");
endmodule

// ### bench/fbm_board_model.sv
// board reset controller and strap resistors facing the mode block
`timescale 1ns/10ps
module fbm_board_model (
    // clock
    input wire logic clk_i,
    // reset and strap pins
    output logic rst_o,
    output logic width_lo_o,
    output logic width_hi_o,
    output logic loader_n_o,
    output logic ilv_o
);
    // power-up: reset asserted, every strap at a firm level
    initial begin
        rst_o = 1'b1;
        {width_lo_o, width_hi_o, loader_n_o, ilv_o} = 4'hf;
    end

    // straps settle under reset; don't-care pins still get a level
    task automatic apply(input logic [3:0] straps, input int hold,
                         input logic release_rst);
        @(posedge clk_i);
        rst_o <= 1'b1;
        {width_lo_o, width_hi_o, loader_n_o, ilv_o} <= straps;
        repeat (hold) @(posedge clk_i);
        rst_o <= ~release_rst;
    endtask

    // shared pins reused as port bits; width straps never move
    task automatic use_gpio();
        @(posedge clk_i);
        loader_n_o <= ~loader_n_o;
        ilv_o <= ~ilv_o;
    endtask
endmodule

// ### bench/tb.sv
// self-checking bench for the strap mode latch and address decoder
`timescale 1ns/10ps
module tb;
    import fbm_pkg::*;
    logic sys_clk_i, rst, wlo, whi, ldr_n, ilv, ub_sel, cpu_write;
    logic [31:0] cpu_addr;
    fbm_mode_e mode;
    logic valid, run, brom_fetch, intl, free, short_rst, p16;
    logic sf, sb, sr, vhit, wr_ok;
    logic [2:0] blk;
    logic [19:0] ofs;
    int miscompares = 0;
    int samples_checked = 0;

    fbm_board_model fbm_board_model_i (.clk_i(sys_clk_i), .rst_o(rst),
        .width_lo_o(wlo), .width_hi_o(whi), .loader_n_o(ldr_n),
        .ilv_o(ilv));

    fbm_mode_ctl fbm_mode_ctl_i (.sys_clk_i(sys_clk_i), .sys_rst_i(rst),
        .width_strap_lo_i(wlo), .width_strap_hi_i(whi),
        .loader_strap_n_i(ldr_n), .port_j_bit3_i(ilv),
        .user_boot_sel_i(ub_sel), .cpu_addr_i(cpu_addr),
        .cpu_write_i(cpu_write), .mode_o(mode), .mode_valid_o(valid),
        .cpu_run_o(run), .fetch_brom_o(brom_fetch), .interleave_o(intl),
        .straps_free_o(free), .reset_short_o(short_rst),
        .prog_16bit_o(p16), .sel_flash_o(sf), .sel_brom_o(sb),
        .sel_ram_o(sr), .vector_hit_o(vhit), .flash_blk_o(blk),
        .flash_ofs_o(ofs), .flash_wr_ok_o(wr_ok));

    // 200 MHz system clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // expected is {flash, brom, ram, write permitted}; cpu_write is left as the caller set it
    task automatic probe(input logic [31:0] a, input logic [3:0] exp);
        @(posedge sys_clk_i);
        cpu_addr <= a;
        #1;
        chk("select", 32'(exp), 32'({sf, sb, sr, wr_ok}));
    endtask

    // bounded wait for the latched mode to become valid
    task automatic start_mode(input logic [3:0] straps, input int hold);
        int n;
        fbm_board_model_i.apply(straps, hold, 1'b1);
        n = 0;
        while (valid !== 1'b1 && n < 10) begin
            @(posedge sys_clk_i);
            n++;
        end
        #1;
        if (n >= 10) begin
            miscompares++;
            $display("MISMATCH mode_valid expected 1 seen %b", valid);
            print_verdict();
        end
    endtask

    // expected status flags {run, brom fetch, interleave, 16-bit prog}
    task automatic status(input fbm_mode_e m, input logic [3:0] f);
        chk("mode", 32'(m), 32'(mode));
        chk("flags", 32'(f), 32'({run, brom_fetch, intl, p16}));
    endtask

    initial begin
        ub_sel = 1'b0;
        cpu_write = 1'b1;
        cpu_addr = 32'h0000_0000;
        // single-chip normal: flash fetch, shadow window, no writes
        start_mode(4'hf, 20);
        status(FBM_MODE_SCHIP, 4'b1010);
        chk("free", 32'h1, 32'(free));
        chk("short", 32'h0, 32'(short_rst));
        probe(32'h1fc0_0400, 4'b1000);
        chk("vector", 32'h0, 32'(vhit));
        probe(32'h1fc0_03fc, 4'b1000);
        chk("vector", 32'h1, 32'(vhit));
        probe(32'h4000_0000, 4'b1000);
        probe(32'h1fd0_0000, 4'b0000);
        probe(32'hfffd_6000, 4'b0010);
        probe(32'hfffe_0000, 4'b0000);
        ub_sel <= 1'b1;
        // user boot: every 128 KB block, writes permitted
        for (int n = 0; n < 8; n++) begin
            probe(32'h1fc0_0000 + n * 32'h2_0000 + 32'h1_fffc,
                  4'b1001);
            chk("blk", 32'(n), 32'(blk));
            chk("ofs", 32'(n * 20'h2_0000 + 20'h1_fffc), 32'(ofs));
        end
        probe(32'h4002_0000, 4'b1001);
        chk("blk", 32'h1, 32'(blk));
        cpu_write <= 1'b0;
        probe(32'h4002_0000, 4'b1000);
        cpu_write <= 1'b1;
        fbm_board_model_i.use_gpio();
        repeat (3) @(posedge sys_clk_i);
        status(FBM_MODE_SCHIP, 4'b1010);
        $display("test single_chip done");
        // single boot: boot rom fetch, flash only high, reprogramming
        start_mode(4'b1100, 20);
        status(FBM_MODE_SBOOT, 4'b1100);
        probe(32'h1fc0_1fff, 4'b0100);
        probe(32'h1fc0_2000, 4'b0000);
        probe(32'h400f_ffff, 4'b1001);
        $display("test single_boot done");
        // programmer: reset kept low, flash at zero only
        fbm_board_model_i.apply(4'b0100, 20, 1'b0);
        #1;
        status(FBM_MODE_PROG, 4'b0001);
        probe(32'h0002_0000, 4'b1001);
        chk("blk", 32'h1, 32'(blk));
        probe(32'h0010_0000, 4'b0000);
        probe(32'h1fc0_0000, 4'b0000);
        probe(32'hfffd_6000, 4'b0000);
        $display("test programmer done");
        // unlisted straps: interleave low in single-chip is unsupported
        start_mode(4'b1110, 20);
        status(FBM_MODE_BAD, 4'b0000);
        probe(32'h1fc0_0000, 4'b0000);
        // reset shorter than the minimum is flagged
        start_mode(4'hf, 3);
        chk("short", 32'h1, 32'(short_rst));
        $display("test bad_and_short done");
        print_verdict();
    end
endmodule
